// file: verilog/ccd_pkg.sv
// shared constants and carrier types for the card command decoder
package ccd_pkg;
	// command indices handled by the decoder
	localparam logic [5:0] CMD_VOLT_SWITCH = 6'h0b;
	localparam logic [5:0] CMD_HALT = 6'h0c;
	localparam logic [5:0] CMD_STATUS = 6'h0d;
	localparam logic [5:0] CMD_RESERVED = 6'h0e;
	localparam logic [5:0] CMD_DEACTIVATE = 6'h0f;
	localparam logic [5:0] CMD_BLOCK_SIZE = 6'h10;
	localparam logic [5:0] CMD_SINGLE_FETCH = 6'h11;
	localparam logic [5:0] CMD_MULTI_FETCH = 6'h12;
	localparam logic [5:0] CMD_TUNING = 6'h13;
	localparam logic [5:0] CMD_SPEED_CLASS = 6'h14;

	// block sizes and tuning pattern
	localparam logic [31:0] DEFAULT_BLOCK_LEN = 32'h0000_0200;
	localparam logic [31:0] FIXED_BLOCK_LEN = 32'h0000_0200;
	localparam logic [31:0] MAX_BLOCK_LEN = 32'h0000_0200;
	localparam int BLOCK_SHIFT = 9;
	localparam logic [6:0] TUNE_LEN = 7'h40;
	localparam logic [7:0] TUNE_SEED = 8'h5a;

	// argument fields
	localparam int ID_HI = 31;
	localparam int ID_LO = 16;
	localparam int SPEED_HI = 31;
	localparam int SPEED_LO = 28;

	// position of the size fault flag inside the returned status word
	localparam int SIZE_FAULT_POS = 29;

	// bus signalling and speed modes of the card
	typedef enum logic [1:0] {
		MODE_DEFAULT,
		MODE_DOUBLE_RATE,
		MODE_SINGLE_RATE_MID,
		MODE_SINGLE_RATE_TOP
	} ccd_mode_t;

	// kind of reply requested from the response framer
	typedef enum logic [1:0] {
		RESP_NONE,
		RESP_SHORT,
		RESP_SHORT_BUSY
	} ccd_resp_kind_t;

	// a decoded command as taken from the link
	typedef struct packed {
		logic [5:0] index;
		logic [31:0] arg;
	} ccd_cmd_t;

	// one byte of outgoing block data
	typedef struct packed {
		logic last;
		logic [7:0] data;
	} ccd_byte_t;
endpackage

// file: verilog/ccd_decoder.sv
// card command decoder with its outgoing data fifo
`timescale 1ns/1ps
`default_nettype none

module ccd_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_flush,
	// fill side
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [WIDTH-1:0] i_data,
	// drain side
	output logic o_valid,
	input wire logic i_ready,
	output logic [WIDTH-1:0] o_data,
	output logic [$clog2(DEPTH):0] o_level
);
	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wptr;
		logic [PW-1:0] rptr;
		logic [PW:0] count;
	} ccd_fifo_t;

	ccd_fifo_t r;
	ccd_fifo_t next_r;
	logic push;
	logic pop;

	// refused at elaboration: the pointer wrap needs a power-of-two depth
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_fifo
		$error("fifo depth must be a power of two of at least 2");
	end

	assign o_ready = (r.count != (PW + 1)'(DEPTH));
	assign o_valid = (r.count != '0);
	assign o_data = r.mem[r.rptr];
	assign o_level = r.count;
	assign push = i_valid && o_ready;
	assign pop = o_valid && i_ready;

	// pointers wrap naturally since depth is a power of two
	always_comb begin
		next_r = r;
		if (push) begin
			next_r.mem[r.wptr] = i_data;
			next_r.wptr = r.wptr + 1'b1;
		end
		if (pop) begin
			next_r.rptr = r.rptr + 1'b1;
		end
		next_r.count = r.count + (PW + 1)'(push) - (PW + 1)'(pop);
		if (i_flush) begin
			next_r.wptr = '0;
			next_r.rptr = '0;
			next_r.count = '0;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end
endmodule // ccd_fifo

// Contract
// - voltage switch answers a short reply, then moves signalling to the low level.
// - halt ends any data transfer and answers a short reply with busy.
// - status query with matching local id returns the card status word.
// - deactivate with matching local id makes the card inactive, no reply.
// - standard card stores the block size argument as the block byte length.
// - block length is 512 bytes until the block size command changes it.
// - standard card uses the programmed length only if partial reads are allowed.
// - high capacity cards always read 512-byte blocks.
// - programmed length still applies to lock/unlock on high capacity cards.
// - a requested length above 512 bytes sets the size fault flag.
// - single fetch sends one block from the argument address.
// - multi fetch sends consecutive blocks until a halt arrives.
// - multi fetch block length follows the single fetch choice.
// - tuning command sends a 64-byte pattern in the two fastest single-rate modes.
// - speed class takes a code in bits 31..28 and answers with busy.
module ccd_decoder #(
	parameter int FIFO_DEPTH = 4,
	parameter int BUSY_CYCLES = 8
) (
	// core clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// link side: commands framed by the host-clocked front end
	input wire logic i_lk_clk,
	input wire logic i_lk_cmd_valid,
	input wire logic [5:0] i_lk_cmd_index,
	input wire logic [31:0] i_lk_cmd_arg,
	// card configuration, core clock domain
	input wire logic [15:0] i_card_local_id,
	input wire logic i_high_capacity,
	input wire logic i_partial_read_ok,
	input wire ccd_pkg::ccd_mode_t i_speed_mode,
	input wire logic [31:0] i_card_status,
	// reply request to the response framer
	output logic o_resp_valid,
	output ccd_pkg::ccd_resp_kind_t o_resp_kind,
	output logic [31:0] o_resp_data,
	output logic o_busy,
	// card state
	output logic o_low_volt,
	output logic o_inactive,
	output logic o_size_fault_flag,
	output logic [31:0] o_lock_blk_len,
	output logic [3:0] o_speed_ctl,
	output logic o_speed_stb,
	// memory read port
	output logic o_mem_rd,
	output logic [31:0] o_mem_addr,
	input wire logic i_mem_rvalid,
	input wire logic [7:0] i_mem_rdata,
	// outgoing block data
	output logic o_dat_valid,
	output logic [7:0] o_dat_byte,
	output logic o_dat_last,
	input wire logic i_dat_ready
);
	localparam int LVL_W = $clog2(FIFO_DEPTH) + 1;

	typedef enum {
		ST_IDLE,
		ST_READ,
		ST_TUNE
	} ccd_state_t;

	// link domain state: the captured command and its event toggle
	typedef struct packed {
		ccd_pkg::ccd_cmd_t cmd;
		logic toggle;
	} ccd_link_t;

	// core domain state
	typedef struct packed {
		logic sync1;
		logic sync2;
		logic sync3;
		ccd_state_t st;
		logic multi;
		logic [31:0] addr;
		logic [31:0] remain;
		logic [6:0] tcnt;
		logic [7:0] busy_cnt;
		logic busy;
		logic volt_pend;
		logic low_volt;
		logic inactive;
		logic size_fault;
		logic [31:0] blk_len;
		logic resp_valid;
		ccd_pkg::ccd_resp_kind_t resp_kind;
		logic [31:0] resp_data;
		logic [3:0] speed_ctl;
		logic speed_stb;
		logic mem_rd;
		logic dat_valid;
		ccd_pkg::ccd_byte_t dat;
	} ccd_core_t;

	ccd_link_t lk;
	ccd_link_t next_lk;
	ccd_core_t r;
	ccd_core_t next_r;

	logic cmd_evt;
	logic cmd_live;
	logic id_match;
	logic [31:0] eff_len;
	logic flush;
	logic fifo_in_valid;
	logic fifo_in_ready;
	ccd_pkg::ccd_byte_t fifo_in;
	logic fifo_out_valid;
	logic fifo_out_ready;
	ccd_pkg::ccd_byte_t fifo_out;
	logic [LVL_W-1:0] fifo_level;

	// refused at elaboration: the busy counter is eight bits wide
	if (BUSY_CYCLES < 1 || BUSY_CYCLES > 255) begin : g_bad_busy
		$error("busy length must lie between 1 and 255 cycles");
	end

	// link side: capture the command and flip the toggle; the words stay put
	// until the next command, so the host must space commands by a few core cycles
	always_comb begin
		next_lk = lk;
		if (i_lk_cmd_valid) begin
			next_lk.cmd.index = i_lk_cmd_index;
			next_lk.cmd.arg = i_lk_cmd_arg;
			next_lk.toggle = !lk.toggle;
		end
	end

	always_ff @(posedge i_lk_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lk <= '0;
		end else begin
			lk <= next_lk;
		end
	end

	// toggle edge seen after two synchroniser stages marks a new command
	assign cmd_evt = r.sync2 ^ r.sync3;
	assign cmd_live = cmd_evt && !r.inactive;
	assign id_match = (lk.cmd.arg[ccd_pkg::ID_HI:ccd_pkg::ID_LO] == i_card_local_id);

	// block length for memory reads
	always_comb begin
		if (i_high_capacity) begin
			eff_len = ccd_pkg::FIXED_BLOCK_LEN;
		end else if (i_partial_read_ok) begin
			eff_len = r.blk_len;
		end else begin
			eff_len = ccd_pkg::DEFAULT_BLOCK_LEN;
		end
	end

	assign fifo_out_ready = !r.dat_valid || i_dat_ready;

	// fill the fifo from memory or from the tuning generator
	always_comb begin
		fifo_in_valid = 1'b0;
		fifo_in.data = i_mem_rdata;
		fifo_in.last = (r.remain == 32'h0000_0001);
		if (r.st == ST_READ) begin
			fifo_in_valid = r.mem_rd && i_mem_rvalid;
		end else if (r.st == ST_TUNE) begin
			fifo_in_valid = 1'b1;
			fifo_in.data = 8'(r.tcnt) ^ ccd_pkg::TUNE_SEED;
			fifo_in.last = (r.tcnt == ccd_pkg::TUNE_LEN - 7'h01);
		end
	end

	// a halt, or a deactivate with matching id, drops everything still queued
	assign flush = cmd_live && (lk.cmd.index == ccd_pkg::CMD_HALT ||
		(lk.cmd.index == ccd_pkg::CMD_DEACTIVATE && id_match));

	// command decode, data sequencing and replies
	always_comb begin
		next_r = r;
		next_r.sync1 = lk.toggle;
		next_r.sync2 = r.sync1;
		next_r.sync3 = r.sync2;
		next_r.resp_valid = 1'b0;
		next_r.speed_stb = 1'b0;
		// signalling moves only once the reply has gone out
		if (r.resp_valid && r.volt_pend) begin
			next_r.low_volt = 1'b1;
			next_r.volt_pend = 1'b0;
		end
		if (r.busy_cnt != 8'h00) begin
			next_r.busy_cnt = r.busy_cnt - 8'h01;
		end
		// output stage takes a byte whenever it is free or being drained
		if (fifo_out_ready) begin
			next_r.dat_valid = fifo_out_valid;
			next_r.dat = fifo_out;
		end
		// sequencing of the data source
		case (r.st)
			ST_READ: begin
				if (fifo_in_valid) begin
					next_r.addr = r.addr + 32'h0000_0001;
					next_r.remain = r.remain - 32'h0000_0001;
					if (fifo_in.last) begin
						if (r.multi) begin
							next_r.remain = eff_len;
						end else begin
							next_r.st = ST_IDLE;
						end
					end
				end
			end
			ST_TUNE: begin
				if (fifo_in_ready) begin
					next_r.tcnt = r.tcnt + 7'h01;
					if (fifo_in.last) begin
						next_r.st = ST_IDLE;
					end
				end
			end
			default: begin
			end
		endcase
		if (cmd_live) begin
			case (lk.cmd.index)
				ccd_pkg::CMD_VOLT_SWITCH: begin
					if (r.st == ST_IDLE) begin
						next_r.resp_valid = 1'b1;
						next_r.resp_kind = ccd_pkg::RESP_SHORT;
						next_r.volt_pend = 1'b1;
					end
				end
				ccd_pkg::CMD_HALT: begin
					next_r.st = ST_IDLE;
					next_r.dat_valid = 1'b0;
					next_r.resp_valid = 1'b1;
					next_r.resp_kind = ccd_pkg::RESP_SHORT_BUSY;
					next_r.busy_cnt = 8'(BUSY_CYCLES);
				end
				ccd_pkg::CMD_STATUS: begin
					if (id_match) begin
						next_r.resp_valid = 1'b1;
						next_r.resp_kind = ccd_pkg::RESP_SHORT;
						next_r.resp_data = i_card_status;
						next_r.resp_data[ccd_pkg::SIZE_FAULT_POS] = r.size_fault;
						next_r.size_fault = 1'b0; // cleared once reported
					end
				end
				ccd_pkg::CMD_RESERVED: begin
					// nothing happens here on purpose
				end
				ccd_pkg::CMD_DEACTIVATE: begin
					if (id_match) begin
						next_r.inactive = 1'b1;
						next_r.st = ST_IDLE;
						next_r.dat_valid = 1'b0;
					end
				end
				ccd_pkg::CMD_BLOCK_SIZE: begin
					if (r.st == ST_IDLE) begin
						next_r.blk_len = lk.cmd.arg;
						next_r.resp_valid = 1'b1;
						next_r.resp_kind = ccd_pkg::RESP_SHORT;
						if (lk.cmd.arg > ccd_pkg::MAX_BLOCK_LEN) begin
							next_r.size_fault = 1'b1;
						end
					end
				end
				ccd_pkg::CMD_SINGLE_FETCH, ccd_pkg::CMD_MULTI_FETCH: begin
					if (r.st == ST_IDLE) begin
						next_r.st = ST_READ;
						next_r.multi = (lk.cmd.index == ccd_pkg::CMD_MULTI_FETCH);
						next_r.remain = eff_len;
						next_r.addr = i_high_capacity ? (lk.cmd.arg << ccd_pkg::BLOCK_SHIFT) : lk.cmd.arg;
						next_r.resp_valid = 1'b1;
						next_r.resp_kind = ccd_pkg::RESP_SHORT;
					end
				end
				ccd_pkg::CMD_TUNING: begin
					if (r.st == ST_IDLE) begin
						next_r.resp_valid = 1'b1;
						next_r.resp_kind = ccd_pkg::RESP_SHORT;
						if (i_speed_mode == ccd_pkg::MODE_SINGLE_RATE_MID ||
							i_speed_mode == ccd_pkg::MODE_SINGLE_RATE_TOP) begin
							next_r.st = ST_TUNE;
							next_r.tcnt = 7'h00;
						end
					end
				end
				ccd_pkg::CMD_SPEED_CLASS: begin
					next_r.speed_ctl = lk.cmd.arg[ccd_pkg::SPEED_HI:ccd_pkg::SPEED_LO];
					next_r.speed_stb = 1'b1;
					next_r.resp_valid = 1'b1;
					next_r.resp_kind = ccd_pkg::RESP_SHORT_BUSY;
					next_r.busy_cnt = 8'(BUSY_CYCLES);
				end
				default: begin
				end
			endcase
		end
		next_r.busy = (next_r.busy_cnt != 8'h00);
		// ask memory only with two free slots, covering the one-cycle request lag
		next_r.mem_rd = (next_r.st == ST_READ) && !flush &&
			(fifo_level <= LVL_W'(FIFO_DEPTH - 2));
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r <= '0;
			r.st <= ST_IDLE;
			r.resp_kind <= ccd_pkg::RESP_NONE;
			r.blk_len <= ccd_pkg::DEFAULT_BLOCK_LEN;
		end else begin
			r <= next_r;
		end
	end

	ccd_fifo #(
		.WIDTH($bits(ccd_pkg::ccd_byte_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_clk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_flush(flush),
		.i_valid(fifo_in_valid),
		.o_ready(fifo_in_ready),
		.i_data(fifo_in),
		.o_valid(fifo_out_valid),
		.i_ready(fifo_out_ready),
		.o_data(fifo_out),
		.o_level(fifo_level)
	);

	// outputs straight from the state register
	assign o_resp_valid = r.resp_valid;
	assign o_resp_kind = r.resp_kind;
	assign o_resp_data = r.resp_data;
	assign o_busy = r.busy;
	assign o_low_volt = r.low_volt;
	assign o_inactive = r.inactive;
	assign o_size_fault_flag = r.size_fault;
	assign o_lock_blk_len = r.blk_len;
	assign o_speed_ctl = r.speed_ctl;
	assign o_speed_stb = r.speed_stb;
	assign o_mem_rd = r.mem_rd;
	assign o_mem_addr = r.addr;
	assign o_dat_valid = r.dat_valid;
	assign o_dat_byte = r.dat.data;
	assign o_dat_last = r.dat.last;

	// checks on the core domain
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);

	volt_after_reply_a: assert property (
		(cmd_live && lk.cmd.index == ccd_pkg::CMD_VOLT_SWITCH && r.st == ST_IDLE)
		|=> (o_resp_valid && !o_low_volt) ##1 o_low_volt)
		else $error("signalling level did not follow the voltage switch reply");
	halt_stops_data_a: assert property (
		(cmd_live && lk.cmd.index == ccd_pkg::CMD_HALT)
		|=> (r.st == ST_IDLE && !o_dat_valid && !o_mem_rd && o_resp_valid
		&& o_resp_kind == ccd_pkg::RESP_SHORT_BUSY && o_busy))
		else $error("halt did not stop the transfer with a busy reply");
	status_reply_a: assert property (
		(cmd_live && lk.cmd.index == ccd_pkg::CMD_STATUS && id_match)
		|=> (o_resp_valid && o_resp_kind == ccd_pkg::RESP_SHORT
		&& o_resp_data[ccd_pkg::SIZE_FAULT_POS] == $past(r.size_fault)))
		else $error("status query gave no status reply");
	deactivate_silent_a: assert property (
		(cmd_live && lk.cmd.index == ccd_pkg::CMD_DEACTIVATE && id_match)
		|=> (o_inactive && !o_resp_valid) ##1 (o_inactive && !o_resp_valid))
		else $error("deactivate replied or did not take effect");
	size_store_a: assert property (
		(cmd_live && lk.cmd.index == ccd_pkg::CMD_BLOCK_SIZE && r.st == ST_IDLE)
		|=> (o_lock_blk_len == $past(lk.cmd.arg)))
		else $error("block size argument was not stored");
	size_fault_set_a: assert property (
		(cmd_live && lk.cmd.index == ccd_pkg::CMD_BLOCK_SIZE && r.st == ST_IDLE
		&& lk.cmd.arg > ccd_pkg::MAX_BLOCK_LEN) |=> o_size_fault_flag)
		else $error("oversize block length did not raise the fault flag");
	fixed_block_a: assert property (
		(cmd_live && (lk.cmd.index == ccd_pkg::CMD_SINGLE_FETCH || lk.cmd.index == ccd_pkg::CMD_MULTI_FETCH)
		&& r.st == ST_IDLE && i_high_capacity)
		|=> (r.remain == ccd_pkg::FIXED_BLOCK_LEN && r.multi == $past(lk.cmd.index == ccd_pkg::CMD_MULTI_FETCH)))
		else $error("high capacity read did not use the fixed block");
	tune_start_a: assert property (
		(cmd_live && lk.cmd.index == ccd_pkg::CMD_TUNING && r.st == ST_IDLE
		&& i_speed_mode == ccd_pkg::MODE_SINGLE_RATE_TOP) |=> (r.st == ST_TUNE && r.tcnt == 7'h00))
		else $error("tuning pattern did not start");
	speed_code_a: assert property (
		(cmd_live && lk.cmd.index == ccd_pkg::CMD_SPEED_CLASS)
		|=> (o_speed_stb && o_speed_ctl == $past(lk.cmd.arg[ccd_pkg::SPEED_HI:ccd_pkg::SPEED_LO]) && o_busy))
		else $error("speed class code not taken");
	reserved_idle_a: assert property (
		(cmd_live && lk.cmd.index == ccd_pkg::CMD_RESERVED)
		|=> (!o_resp_valid && $stable(o_lock_blk_len) && $stable(o_inactive)))
		else $error("reserved command had an effect");
endmodule // ccd_decoder

`default_nettype wire

// file: bench/ccd_host_model.sv
// host side model: link clock bursts and framed commands
`timescale 1ns/1ps
`default_nettype none
module ccd_host_model (
	// link outputs toward the card
	output logic o_lk_clk,
	output logic o_valid,
	output logic [5:0] o_index,
	output logic [31:0] o_arg
);
	// clock stands still outside frames; words stay put so the core can pick them up late
	initial begin
		o_lk_clk = 1'b0;
		o_valid = 1'b0;
		o_index = 6'h00;
		o_arg = 32'h0000_0000;
	end

	// one link period of 80 ns
	task automatic tick();
		#40 o_lk_clk = 1'b1;
		#40 o_lk_clk = 1'b0;
	endtask

	// two idle edges, one edge carrying the command, one trailing edge
	task automatic send(input logic [5:0] idx, input logic [31:0] arg);
		tick();
		tick();
		#1 o_index = idx;
		o_arg = arg;
		o_valid = 1'b1;
		#39 o_lk_clk = 1'b1;
		#1 o_valid = 1'b0;
		#39 o_lk_clk = 1'b0;
		tick();
	endtask
endmodule // ccd_host_model
`default_nettype wire

// file: bench/tb_top.sv
// self-checking bench for the card command decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic i_mclk, i_rst_n, lk_clk, lk_v, hc, pok, rd_v, d_rdy;
	logic [5:0] lk_idx;
	logic [15:0] id;
	logic [7:0] rd_d;
	logic [31:0] lk_arg, status, t, mt, len, base, seed, rsp_d, blk, addr, last_data;
	ccd_pkg::ccd_mode_t mode;
	ccd_pkg::ccd_resp_kind_t rsp_k, last_kind;
	logic rsp_v, busy, lowv, inact, fault, stb, mem_rd, d_v, d_last;
	logic [3:0] spd;
	logic [7:0] d_b;
	logic [8:0] q[$];
	int fail_count, n_compared, n_resp, n_stb, bcnt, busy_run, n0;

	ccd_host_model i_host (.o_lk_clk(lk_clk), .o_valid(lk_v), .o_index(lk_idx), .o_arg(lk_arg));

	ccd_decoder #(.FIFO_DEPTH(4), .BUSY_CYCLES(8)) i_dut (
		.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_lk_clk(lk_clk), .i_lk_cmd_valid(lk_v),
		.i_lk_cmd_index(lk_idx), .i_lk_cmd_arg(lk_arg), .i_card_local_id(id),
		.i_high_capacity(hc), .i_partial_read_ok(pok), .i_speed_mode(mode), .i_card_status(status),
		.o_resp_valid(rsp_v), .o_resp_kind(rsp_k), .o_resp_data(rsp_d), .o_busy(busy),
		.o_low_volt(lowv), .o_inactive(inact), .o_size_fault_flag(fault), .o_lock_blk_len(blk),
		.o_speed_ctl(spd), .o_speed_stb(stb), .o_mem_rd(mem_rd), .o_mem_addr(addr),
		.i_mem_rvalid(rd_v), .i_mem_rdata(rd_d), .o_dat_valid(d_v), .o_dat_byte(d_b),
		.o_dat_last(d_last), .i_dat_ready(d_rdy));

	// xorshift source, fixed start keeps runs repeatable
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// send a command, let the crossing settle, count replies
	// a local start count, so callers may keep their own counters in n0
	task automatic cmd(input logic [5:0] idx, input logic [31:0] arg, input int nr);
		int n_before;
		n_before = n_resp;
		i_host.send(idx, arg);
		repeat (10) @(posedge i_mclk);
		#1;
		check("reply count", 32'(n_resp - n_before), 32'(nr));
	endtask

	// bounded wait for delivered bytes; a timeout ends the run
	task automatic wait_bytes(input int n);
		for (int i = 0; i < 30000 && q.size() < n; i++) @(posedge i_mclk);
		#1;
		if (q.size() < n) begin
			fail_count++;
			tally_and_finish();
		end
	endtask

	// compare one block against memory contents (or the tuning pattern when tune is set) and the last-byte marker
	task automatic take_block(input logic [31:0] b, input int n, input logic tune);
		logic [31:0] a;
		for (int k = 0; k < n; k++) begin
			a = tune ? 32'(k) : b + 32'(k);
			check("byte", 32'(q[0][7:0]), 32'(a[7:0] ^ (tune ? ccd_pkg::TUNE_SEED : 8'hc3)));
			check("last", 32'(q[0][8]), 32'(k == n - 1));
			void'(q.pop_front());
		end
	endtask

	// core clock, 4 ns
	initial begin
		i_mclk = 1'b0;
		forever #2 i_mclk = ~i_mclk;
	end

	// observe replies, strobes, delivered bytes and busy length
	always @(posedge i_mclk) begin
		if (rsp_v) begin
			n_resp++;
			last_kind = rsp_k;
			last_data = rsp_d;
		end
		if (stb) n_stb++;
		if (d_v && d_rdy) q.push_back({d_last, d_b});
		if (busy) bcnt++;
		else if (bcnt != 0) begin
			busy_run = bcnt;
			bcnt = 0;
		end
	end

	// memory answers with address-derived data; consumer stalls half the time
	always @(posedge i_mclk) begin
		#1;
		mt = rnd();
		rd_v = mt[0] | mt[1];
		rd_d = addr[7:0] ^ 8'hc3;
		d_rdy = mt[2];
	end

	// watchdog on the whole run
	initial begin
		repeat (100000) @(posedge i_mclk);
		fail_count++;
		tally_and_finish();
	end

	initial begin
		seed = 32'h0000_955d;
		{i_rst_n, hc, pok, rd_v, d_rdy, fail_count, n_compared, n_resp, n_stb, bcnt, busy_run} = '0;
		rd_d = 8'h00;
		mode = ccd_pkg::MODE_DEFAULT;
		id = 16'(rnd() >> 16);
		status = rnd() & 32'hdfff_ffff;
		repeat (16) @(posedge i_mclk);
		#1 i_rst_n = 1'b1;
		@(posedge i_mclk);
		#1;
		check("length at reset", blk, 32'h0000_0200);
		check("flags at reset", 32'({lowv, inact, fault}), 32'h0000_0000);
		// status query: foreign id ignored, own id answered
		cmd(ccd_pkg::CMD_STATUS, {id ^ 16'h0001, 16'h0000}, 0);
		cmd(ccd_pkg::CMD_STATUS, {id, 16'h1234}, 1);
		check("status word", last_data, status);
		check("status kind", 32'(last_kind), 32'(ccd_pkg::RESP_SHORT));
		cmd(ccd_pkg::CMD_RESERVED, rnd(), 0);
		check("length kept", blk, 32'h0000_0200);
		// oversize length is stored yet flagged; the status read reports then clears it
		cmd(ccd_pkg::CMD_BLOCK_SIZE, 32'h0000_0300, 1);
		check("fault set", 32'(fault), 32'h1);
		check("lock length", blk, 32'h0000_0300);
		cmd(ccd_pkg::CMD_STATUS, {id, 16'h0000}, 1);
		check("status fault", last_data, status | 32'h2000_0000);
		check("fault cleared", 32'(fault), 32'h0);
		// single fetch: standard partial, standard whole, high capacity
		for (int c = 0; c < 3; c++) begin
			hc = (c == 2);
			pok = (c == 0);
			t = rnd();
			len = 32'(2 + 2 * t[3:0]); // even length
			cmd(ccd_pkg::CMD_BLOCK_SIZE, len, 1);
			check("set length", blk, len);
			t = rnd() & 32'h0000_ffff;
			base = hc ? t << 9 : t;
			if (!pok || hc) len = 32'h0000_0200;
			cmd(ccd_pkg::CMD_SINGLE_FETCH, t, 1);
			wait_bytes(int'(len));
			take_block(base, int'(len), 1'b0);
			repeat (60) @(posedge i_mclk);
			#1;
			check("extra bytes", 32'(q.size()), 32'h0);
		end
		// multi fetch runs block after block until halted
		hc = 1'b0;
		pok = 1'b1;
		cmd(ccd_pkg::CMD_BLOCK_SIZE, 32'h0000_0010, 1);
		cmd(ccd_pkg::CMD_MULTI_FETCH, 32'h0000_0100, 1);
		wait_bytes(48);
		for (int b = 0; b < 3; b++) take_block(32'h0000_0100 + 32'(16 * b), 16, 1'b0);
		busy_run = 0;
		cmd(ccd_pkg::CMD_HALT, rnd(), 1);
		check("halt kind", 32'(last_kind), 32'(ccd_pkg::RESP_SHORT_BUSY));
		check("halt busy", 32'(busy_run), 32'h8);
		repeat (20) @(posedge i_mclk);
		q.delete();
		repeat (60) @(posedge i_mclk);
		#1;
		check("bytes after halt", 32'(q.size()), 32'h0);
		check("reads after halt", 32'(mem_rd), 32'h0);
		// tuning pattern only in the two fastest single-rate modes
		for (int m = 0; m < 4; m++) begin
			mode = ccd_pkg::ccd_mode_t'(m);
			cmd(ccd_pkg::CMD_TUNING, 32'h0000_0000, 1);
			if (m >= 2) wait_bytes(64);
			if (m >= 2) take_block(32'h0, 64, 1'b1);
			repeat (100) @(posedge i_mclk);
			#1;
			check("tuning leftover", 32'(q.size()), 32'h0);
		end
		// speed class: code in the top nibble, rest zero from the host
		t = rnd();
		n0 = n_stb;
		busy_run = 0;
		cmd(ccd_pkg::CMD_SPEED_CLASS, {t[3:0], 28'h0}, 1);
		check("speed code", 32'(spd), 32'(t[3:0]));
		check("speed strobe", 32'(n_stb - n0), 32'h1);
		check("speed kind", 32'(last_kind), 32'(ccd_pkg::RESP_SHORT_BUSY));
		check("speed busy", 32'(busy_run), 32'h8);
		cmd(ccd_pkg::CMD_VOLT_SWITCH, 32'h0000_0000, 1);
		check("volt kind", 32'(last_kind), 32'(ccd_pkg::RESP_SHORT));
		check("low signalling", 32'(lowv), 32'h1);
		// deactivate: low argument half zero, foreign id ignored, then silence
		cmd(ccd_pkg::CMD_DEACTIVATE, {id ^ 16'h8000, 16'h0000}, 0);
		check("still active", 32'(inact), 32'h0);
		cmd(ccd_pkg::CMD_DEACTIVATE, {id, 16'h0000}, 0);
		check("inactive", 32'(inact), 32'h1);
		cmd(ccd_pkg::CMD_STATUS, {id, 16'h0000}, 0);
		tally_and_finish();
	end
endmodule // tb_top
`default_nettype wire
